// ### include/mcir_if.sv
// Carrier between the interrupt routing top and its source and self-test modules.
`timescale 1ns/1ps
interface mcir_if
  import mcir_pkg::*;
#(
  parameter int NUM_DMA = NUM_DMA_SRC
) (
  input wire logic mclk,
  input wire logic rstn
);
  logic [NUM_DMA-1:0] periph_req;
  logic [NUM_DMA-1:0] dma_en;
  logic [NUM_DMA-1:0] dma_done;
  logic [NUM_DMA-1:0] dma_trig;
  logic [NUM_PERIPH-1:0] direct_irq;
  logic [NUM_ANALOG-1:0] analog;
  logic [NUM_PERIPH-1:0] raw;
  logic [NUM_PERIPH-1:0] pass;
  logic st_start;
  logic st_done;
  logic st_fail;
  logic st_busy;
  logic err_nmi;
  modport top (input raw, pass, st_busy, err_nmi, dma_trig,
    output periph_req, dma_en, dma_done, direct_irq, analog, st_start, st_done, st_fail);
  modport route (input mclk, rstn, periph_req, dma_en, dma_done, direct_irq, analog,
    output raw, dma_trig);
  modport st (input mclk, rstn, raw, st_start, st_done, st_fail,
    output pass, st_busy, err_nmi);
endinterface

// ### include/mcir_pkg.sv
// Constants and types shared by the master processor interrupt routing block.
package mcir_pkg;
  localparam int VEC_W = 8;
  localparam int NUM_VEC = 108;
  localparam int NUM_PERIPH = 92;
  localparam int NUM_DMA_SRC = 32;
  localparam int VEC_PERIPH_BASE = 16;
  localparam int VEC_RESET = 1;
  localparam int VEC_NMI = 2;
  localparam int VEC_HFAULT = 3;
  localparam int VEC_MEM_FAULT = 4;
  localparam int VEC_USAGE_FAULT = 6;
  localparam int VEC_CORE_LAST = 15;
  localparam int NUM_FAULT = 3;
  localparam int ANALOG_BASE = 72;
  localparam int NUM_ANALOG = 8;
  localparam int VEC_ADDR_SHIFT = 2;
  localparam int ADDR_W = VEC_W + VEC_ADDR_SHIFT;
  localparam logic [1:0] LVL_RESET = 2'h3;
  localparam logic [1:0] LVL_NMI = 2'h2;
  localparam logic [1:0] LVL_HFAULT = 2'h1;
  localparam logic [1:0] LVL_PROG = 2'h0;
  localparam logic [VEC_W-1:0] VEC_RST_VAL = 8'h00;
  typedef enum logic [1:0] {
    MCIR_IDLE = 2'b01,
    MCIR_PRESENT = 2'b10
  } mcir_state_t;
endpackage

// ### logic/mcir_route.sv
// Source routing between the DMA handshake and the interrupt controller.
`timescale 1ns/1ps
module mcir_route
  import mcir_pkg::*;
#(
  parameter int NUM_DMA = NUM_DMA_SRC
) (
  mcir_if.route bus
);
  import mcir_pkg::*;

  assign bus.dma_trig = bus.periph_req & bus.dma_en;

  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g++)
    begin : g_src
      if (g < NUM_DMA)
      begin : g_dma
        assign bus.raw[g] = bus.dma_en[g] ? bus.dma_done[g] : bus.periph_req[g];
      end
      else if (g >= ANALOG_BASE && g < ANALOG_BASE + NUM_ANALOG)
      begin : g_adc
        assign bus.raw[g] = bus.direct_irq[g] | bus.analog[g-ANALOG_BASE];
      end
      else
      begin : g_dir
        assign bus.raw[g] = bus.direct_irq[g];
      end
    end
  endgenerate

  a_dma_done_irq: assert property (@(posedge bus.mclk) disable iff (!bus.rstn)
    bus.dma_en[0] |-> (bus.raw[0] == bus.dma_done[0] && bus.dma_trig[0] == bus.periph_req[0]))
    else $error("Enabled DMA channel did not route done to the interrupt.");
  a_req_direct: assert property (@(posedge bus.mclk) disable iff (!bus.rstn)
    !bus.dma_en[0] |-> (bus.raw[0] == bus.periph_req[0] && !bus.dma_trig[0]))
    else $error("Disabled DMA channel did not drive the interrupt directly.");
  a_analog_direct: assert property (@(posedge bus.mclk) disable iff (!bus.rstn)
    bus.analog[NUM_ANALOG-1] |-> bus.raw[ANALOG_BASE+NUM_ANALOG-1])
    else $error("Analog conversion interrupt did not reach the controller.");
endmodule

// ### logic/mcir_selftest.sv
// Core logic self-test interrupt logging, reissue and error signalling.
`timescale 1ns/1ps
module mcir_selftest
  import mcir_pkg::*;
(
  mcir_if.st bus
);
  import mcir_pkg::*;

  logic busy_ff;
  logic err_ff;
  logic [NUM_PERIPH-1:0] log_ff;
  logic finish;

  assign finish = busy_ff & bus.st_done;
  assign bus.st_busy = busy_ff;
  assign bus.err_nmi = err_ff;
  // On the closing cycle the log and fresh arrivals pass together, so nothing is dropped.
  assign bus.pass = (busy_ff && !bus.st_done) ? '0 : (bus.raw | log_ff);

  always_ff @(posedge bus.mclk or negedge bus.rstn)
  begin
    if (!bus.rstn)
      busy_ff <= 1'b0;
    else if (finish)
      busy_ff <= 1'b0;
    else if (bus.st_start)
      busy_ff <= 1'b1;
  end

  always_ff @(posedge bus.mclk or negedge bus.rstn)
  begin
    if (!bus.rstn)
      log_ff <= '0;
    else if (finish)
      log_ff <= '0;
    else if (busy_ff)
      log_ff <= log_ff | bus.raw;
  end

  always_ff @(posedge bus.mclk or negedge bus.rstn)
  begin
    if (!bus.rstn)
      err_ff <= 1'b0;
    else
      err_ff <= finish & bus.st_fail;
  end

  sequence s_logged;
    busy_ff && !bus.st_done && bus.raw[0];
  endsequence
  sequence s_flush;
    bus.st_done && busy_ff;
  endsequence

  a_log_keep: assert property (@(posedge bus.mclk) disable iff (!bus.rstn)
    s_logged ##1 s_flush |-> bus.pass[0])
    else $error("Interrupt logged during self-test was not reissued.");
  a_err_nmi: assert property (@(posedge bus.mclk) disable iff (!bus.rstn)
    s_flush and bus.st_fail |=> bus.err_nmi ##1 !bus.err_nmi)
    else $error("Self-test logic error did not raise a one-cycle NMI.");
endmodule

// ### logic/mcir_top.sv
// Interrupt routing and fixed-priority vector presentation for the master processor.
`timescale 1ns/1ps
module mcir_top
  import mcir_pkg::*;
#(
  parameter int NUM_DMA = mcir_pkg::NUM_DMA_SRC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cpu_power_on_reset_req,
  input wire logic cpu_system_reset_req,
  input wire logic nmi_block_req,
  input wire logic [mcir_pkg::VEC_CORE_LAST:mcir_pkg::VEC_MEM_FAULT] core_exc_req,
  input wire logic [mcir_pkg::NUM_FAULT-1:0] fault_enable,
  input wire logic [NUM_DMA-1:0] periph_dma_req,
  input wire logic [NUM_DMA-1:0] dma_chan_en,
  input wire logic [NUM_DMA-1:0] dma_done_irq,
  input wire logic [mcir_pkg::NUM_PERIPH-1:0] direct_irq,
  input wire logic [mcir_pkg::NUM_ANALOG-1:0] analog_conversion_int,
  input wire logic nmi_wdog_evt,
  input wire logic self_test_start,
  input wire logic self_test_done,
  input wire logic self_test_fail,
  input wire logic irq_ack,
  output logic [NUM_DMA-1:0] dma_trigger,
  output logic irq_valid,
  output logic [mcir_pkg::VEC_W-1:0] irq_vector,
  output logic [1:0] irq_level,
  output logic [mcir_pkg::ADDR_W-1:0] irq_vec_addr,
  output logic cpu_nonmask_int,
  output logic cpu_hard_fault,
  output logic ctrl_core_nmi,
  output logic wdog_reset_evt,
  output logic self_test_busy
);
  import mcir_pkg::*;

  mcir_state_t state_ff;
  logic [NUM_VEC-1:0] pend_ff;
  logic [NUM_VEC-1:0] set_vec;
  logic [NUM_VEC-1:0] clr_vec;
  logic [VEC_W-1:0] vector_ff;
  logic [1:0] level_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic wdog_ff;
  logic escalate;
  logic [VEC_W-1:0] win;
  logic any_pend;
  logic [NUM_FAULT-1:0] fault_req;
  logic [NUM_FAULT-1:0] fault_busy;

  mcir_if #(.NUM_DMA(NUM_DMA)) bus (
    .mclk(mclk),
    .rstn(rstn)
  );

  assign bus.periph_req = periph_dma_req;
  assign bus.dma_en = dma_chan_en;
  assign bus.dma_done = dma_done_irq;
  assign bus.direct_irq = direct_irq;
  assign bus.analog = analog_conversion_int;
  assign bus.st_start = self_test_start;
  assign bus.st_done = self_test_done;
  assign bus.st_fail = self_test_fail;

  mcir_route #(.NUM_DMA(NUM_DMA)) u_route (
    .bus(bus.route)
  );

  mcir_selftest u_selftest (
    .bus(bus.st)
  );

  // Lowest pending vector number wins, which also orders the fixed levels.
  function automatic logic [VEC_W-1:0] first_set(input logic [NUM_VEC-1:0] v);
    logic [VEC_W-1:0] idx;
    idx = '0;
    for (int i = NUM_VEC - 1; i > 0; i--)
    begin
      if (v[i])
        idx = VEC_W'(i);
    end
    return idx;
  endfunction

  function automatic logic [1:0] vec_level(input logic [VEC_W-1:0] v);
    logic [1:0] lvl;
    lvl = LVL_PROG;
    if (v == VEC_W'(VEC_RESET))
      lvl = LVL_RESET;
    else if (v == VEC_W'(VEC_NMI))
      lvl = LVL_NMI;
    else if (v == VEC_W'(VEC_HFAULT))
      lvl = LVL_HFAULT;
    return lvl;
  endfunction

  assign fault_req = core_exc_req[VEC_USAGE_FAULT:VEC_MEM_FAULT];
  assign fault_busy = pend_ff[VEC_USAGE_FAULT:VEC_MEM_FAULT];
  // A fault that is disabled or arrives while still pending escalates to hard fault.
  assign escalate = |(fault_req & (~fault_enable | fault_busy));

  always_comb
  begin
    set_vec = '0;
    set_vec[VEC_RESET] = cpu_power_on_reset_req | cpu_system_reset_req;
    set_vec[VEC_NMI] = nmi_block_req | bus.err_nmi;
    set_vec[VEC_HFAULT] = escalate;
    for (int v = VEC_MEM_FAULT; v <= VEC_CORE_LAST; v++)
    begin
      if (v <= VEC_USAGE_FAULT)
        set_vec[v] = core_exc_req[v] & fault_enable[v-VEC_MEM_FAULT] & ~pend_ff[v];
      else
        set_vec[v] = core_exc_req[v];
    end
    for (int n = 0; n < NUM_PERIPH; n++)
    begin
      set_vec[n+VEC_PERIPH_BASE] = bus.pass[n];
    end
  end

  always_comb
  begin
    clr_vec = '0;
    for (int v = 1; v < NUM_VEC; v++)
    begin
      if (state_ff == MCIR_PRESENT && irq_ack && vector_ff == VEC_W'(v))
        clr_vec[v] = 1'b1;
    end
  end

  // A new request in the cycle of its acknowledge stays pending, except a fault on vectors 4 to 6, which escalates to hard fault.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pend_ff <= '0;
    else
      pend_ff <= (pend_ff & ~clr_vec) | set_vec;
  end

  assign any_pend = |pend_ff;
  assign win = first_set(pend_ff);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state_ff <= MCIR_IDLE;
    else
    begin
      case (state_ff)
        MCIR_IDLE:
        begin
          if (any_pend)
            state_ff <= MCIR_PRESENT;
        end
        MCIR_PRESENT:
        begin
          if (irq_ack && !(any_pend && win < vector_ff))
            state_ff <= MCIR_IDLE;
        end
        default:
          state_ff <= MCIR_IDLE;
      endcase
    end
  end

  // A more urgent vector replaces the one on offer before it is taken.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      vector_ff <= VEC_RST_VAL;
      level_ff <= LVL_PROG;
      addr_ff <= '0;
    end
    else if (any_pend && (state_ff == MCIR_IDLE || win < vector_ff))
    begin
      vector_ff <= win;
      level_ff <= vec_level(win);
      addr_ff <= {win, VEC_ADDR_SHIFT'(0)};
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      wdog_ff <= 1'b0;
    else
      wdog_ff <= nmi_wdog_evt;
  end

  assign dma_trigger = bus.dma_trig;
  assign irq_valid = (state_ff == MCIR_PRESENT);
  assign irq_vector = vector_ff;
  assign irq_level = level_ff;
  assign irq_vec_addr = addr_ff;
  assign cpu_nonmask_int = pend_ff[VEC_NMI];
  assign cpu_hard_fault = pend_ff[VEC_HFAULT];
  assign ctrl_core_nmi = bus.err_nmi;
  assign wdog_reset_evt = wdog_ff;
  assign self_test_busy = bus.st_busy;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_reset_req;
    cpu_power_on_reset_req || cpu_system_reset_req;
  endsequence

  a_reset_top: assert property (s_reset_req |-> ##2
    (irq_valid && irq_vector == VEC_W'(VEC_RESET) && irq_level == LVL_RESET))
    else $error("Reset request not presented at level three.");
  a_nmi_level: assert property (nmi_block_req && !irq_valid |-> ##2
    (irq_valid && irq_vector <= VEC_W'(VEC_NMI) && irq_level >= LVL_NMI))
    else $error("Non-maskable interrupt not presented at level two.");
  a_fault_escal: assert property (fault_req[0] && !fault_enable[0] |=>
    cpu_hard_fault)
    else $error("Disabled fault did not escalate to hard fault.");
  a_wdog_only: assert property (nmi_wdog_evt |=> wdog_reset_evt && !$changed(pend_ff[VEC_NMI])
    || nmi_block_req || $past(nmi_block_req) || $past(bus.err_nmi) || $past(irq_ack))
    else $error("Watchdog event not forwarded only to reset logic.");
  a_periph_map: assert property (bus.pass[0] |=> pend_ff[VEC_PERIPH_BASE])
    else $error("Peripheral bit zero did not set vector sixteen.");
  a_core_vec: assert property (core_exc_req[VEC_CORE_LAST] |=> pend_ff[VEC_CORE_LAST])
    else $error("Core exception did not reach its low vector.");
  a_arb_order: assert property (irq_valid && !irq_ack |=> irq_valid
    && irq_vector <= $past(irq_vector))
    else $error("Arbitration offered a less urgent vector before acknowledge.");
  a_vec_addr: assert property (irq_valid |-> irq_vec_addr == {irq_vector, 2'h0}
    && irq_level == vec_level(irq_vector))
    else $error("Vector address is not four times the vector number.");
endmodule

// ### test/mcir_core_model.sv
// Processor core model that takes each offered vector after a chosen delay.
`timescale 1ns/1ps
module mcir_core_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic irq_valid,
  output logic irq_ack
);
  int wait_cnt;
  always @(negedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_ack <= 1'b0;
      wait_cnt <= 0;
    end
    else if (irq_ack)
    begin
      irq_ack <= 1'b0;
      wait_cnt <= 0;
    end
    else if (irq_valid)
    begin
      // A slow core leaves room for a lower vector to preempt the offer.
      if (wait_cnt >= (slow ? 4 : 0))
        irq_ack <= 1'b1;
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// ### test/mcir_tb_top.sv
// Self-checking bench for the interrupt routing block.
`timescale 1ns/1ps
module mcir_tb_top;
  import mcir_pkg::*;
  logic mclk = 0, rstn = 0, por = 0, sysr = 0, nmi = 0, wdog = 0, slow = 0;
  logic st_start = 0, st_done = 0, st_fail = 0, irq_ack, irq_valid;
  logic [15:4] exc = '0;
  logic [2:0] fen = '0;
  logic [31:0] dreq = '0, den = '0, ddone = '0, dtrig;
  logic [91:0] dirq = '0;
  logic [7:0] adc = '0;
  logic [7:0] vec;
  logic [1:0] lvl;
  logic [9:0] vaddr;
  logic nmi_o, hf_o, other_nmi, wdog_o, busy;
  int err_count = 0, n_tests = 0, cycles = 0, k, ch, seed;
  int exp_q[$];
  int e;

  mcir_top i_dut (.mclk(mclk), .rstn(rstn), .cpu_power_on_reset_req(por),
    .cpu_system_reset_req(sysr), .nmi_block_req(nmi), .core_exc_req(exc),
    .fault_enable(fen), .periph_dma_req(dreq), .dma_chan_en(den), .dma_done_irq(ddone),
    .direct_irq(dirq), .analog_conversion_int(adc), .nmi_wdog_evt(wdog),
    .self_test_start(st_start), .self_test_done(st_done), .self_test_fail(st_fail),
    .irq_ack(irq_ack), .dma_trigger(dtrig), .irq_valid(irq_valid), .irq_vector(vec),
    .irq_level(lvl), .irq_vec_addr(vaddr), .cpu_nonmask_int(nmi_o), .cpu_hard_fault(hf_o),
    .ctrl_core_nmi(other_nmi), .wdog_reset_evt(wdog_o), .self_test_busy(busy));
  mcir_core_model i_core (.mclk(mclk), .rstn(rstn), .slow(slow), .irq_valid(irq_valid),
    .irq_ack(irq_ack));

  always #2.5 mclk = ~mclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Every vector the core takes is matched against the next expected one.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      err_count++;
      report_and_stop;
    end
    if (rstn && irq_ack && irq_valid)
    begin
      e = exp_q.size() ? exp_q.pop_front() : 0;
      check("irq_vector", vec, e);
      check("irq_vec_addr", vaddr, e * 4);
      check("irq_level", lvl, e == 1 ? 3 : e == 2 ? 2 : e == 3 ? 1 : 0);
    end
  end

  task automatic drain;
    for (int i = 0; i < 200 && exp_q.size() != 0; i++)
      @(negedge mclk);
    check("undelivered", exp_q.size(), 0);
    repeat (3) @(negedge mclk);
  endtask

  task automatic quiet(input string what);
    repeat (4)
    begin
      @(negedge mclk);
      check(what, irq_valid, 0);
    end
  endtask

  initial
  begin
    seed = $urandom(44849);
    repeat (5) @(negedge mclk);
    rstn = 1;
    @(negedge mclk);
    // Resets, NMI, escalated fault and a peripheral all at once.
    {por, sysr, nmi, exc[4], dirq[40]} = '1;
    exp_q = '{1, 2, 3, 56};
    @(negedge mclk);
    {por, sysr, nmi, exc[4], dirq[40]} = '0;
    check("hard_fault", hf_o, 1);
    drain;
    // Enabled faults and other core exceptions keep their own vectors.
    fen = 3'h7;
    {exc[5], exc[15]} = '1;
    exp_q = '{5, 15};
    @(negedge mclk);
    {exc[5], exc[15]} = '0;
    drain;
    // A slow core sees the NMI preempt a peripheral already on offer.
    slow = 1;
    dirq[40] = 1;
    exp_q = '{2, 56};
    @(negedge mclk);
    dirq[40] = 0;
    repeat (2) @(negedge mclk);
    nmi = 1;
    @(negedge mclk);
    nmi = 0;
    drain;
    slow = 0;
    for (k = 0; k < 8; k++)
    begin
      ch = $urandom % 32;
      den = $urandom;
      dreq[ch] = 1;
      #1 check("dma_trigger", dtrig, dreq & den);
      if (!den[ch])
        exp_q.push_back(ch + 16);
      @(negedge mclk);
      dreq[ch] = 0;
      if (den[ch])
      begin
        quiet("dma_req_no_irq");
        ddone[ch] = 1;
        exp_q.push_back(ch + 16);
        @(negedge mclk);
        ddone[ch] = 0;
      end
      drain;
    end
    adc = 8'hff;
    exp_q = '{88, 89, 90, 91, 92, 93, 94, 95};
    @(negedge mclk);
    adc = 8'h00;
    drain;
    wdog = 1;
    @(negedge mclk);
    wdog = 0;
    check("wdog_reset_evt", wdog_o, 1);
    quiet("wdog_no_irq");
    st_start = 1;
    @(negedge mclk);
    st_start = 0;
    check("busy", busy, 1);
    den = '0;
    dirq[50] = 1;
    dreq[0] = 1;
    @(negedge mclk);
    dirq[50] = 0;
    dreq[0] = 0;
    quiet("held_in_test");
    {st_done, st_fail} = '1;
    // Logged vectors pend at the closing edge, one cycle before the error NMI.
    exp_q = '{16, 2, 66};
    @(negedge mclk);
    {st_done, st_fail} = '0;
    check("other_core_nmi", other_nmi, 1);
    check("busy_end", busy, 0);
    @(negedge mclk);
    check("nmi_pending", nmi_o, 1);
    check("other_nmi_end", other_nmi, 0);
    drain;
    report_and_stop;
  end
endmodule
